// ### logic/irq_vector_defs.svh
// constants for the interrupt source resolver
`ifndef IRQ_VECTOR_DEFS_SVH
`define IRQ_VECTOR_DEFS_SVH

// ----------------------------------------
// request table size
// ----------------------------------------
`define IRQ_COUNT 43
`define IRQ_IDX_W 6
`define RST_SRC_COUNT 7

// ----------------------------------------
// default priority indices, zero highest
// ----------------------------------------
`define PRI_WDT_INTERVAL 6'h00
`define PRI_VOLT_DETECT 6'h01
`define PRI_PIN_EDGE0 6'h02
`define PRI_TIMER_CH2 6'h16
`define PRI_TIMER_CH3 6'h17
`define PRI_SAR_END 6'h18
`define PRI_CALENDAR 6'h19
`define PRI_INTERVAL12 6'h1a
`define PRI_DELTA_SIGMA 6'h1b
`define PRI_TIMER_CH4 6'h1c
`define PRI_TIMER_CH5 6'h1d
`define PRI_PIN_EDGE6 6'h1e
`define PRI_PIN_EDGE7 6'h1f
`define PRI_COMPARATOR0 6'h20
`define PRI_COMPARATOR1 6'h21
`define PRI_TIMER_CH6 6'h22
`define PRI_TIMER_CH7 6'h23
`define PRI_INTERVAL8_00 6'h24
`define PRI_INTERVAL8_01 6'h25
`define PRI_OSC_CORRECT 6'h26
`define PRI_OSC_STOP 6'h27
`define PRI_INTERVAL8_10 6'h28
`define PRI_INTERVAL8_11 6'h29
`define PRI_POWER_SWITCH 6'h2a

// ----------------------------------------
// vector table addresses
// ----------------------------------------
`define VEC_RESET 16'h0000
`define VEC_WDT_INTERVAL 16'h0004
`define VEC_VOLT_DETECT 16'h0006
`define VEC_PIN_EDGE0 16'h0008
`define VEC_TIMER_CH2 16'h0034
`define VEC_TIMER_CH3 16'h0036
`define VEC_SAR_END 16'h0038
`define VEC_CALENDAR 16'h003a
`define VEC_INTERVAL12 16'h003c
`define VEC_DELTA_SIGMA 16'h0044
`define VEC_TIMER_CH4 16'h0046
`define VEC_TIMER_CH5 16'h0048
`define VEC_PIN_EDGE6 16'h004a
`define VEC_PIN_EDGE7 16'h004c
`define VEC_COMPARATOR0 16'h0050
`define VEC_COMPARATOR1 16'h0052
`define VEC_TIMER_CH6 16'h0054
`define VEC_TIMER_CH7 16'h0056
`define VEC_INTERVAL8_00 16'h0058
`define VEC_INTERVAL8_01 16'h005a
`define VEC_OSC_CORRECT 16'h005c
`define VEC_OSC_STOP 16'h0060
`define VEC_INTERVAL8_10 16'h0068
`define VEC_INTERVAL8_11 16'h006a
`define VEC_POWER_SWITCH 16'h006c
`define VEC_SOFT_BREAK 16'h007e

// ----------------------------------------
// opcode, reset cause bits, reset values
// ----------------------------------------
`define OPCODE_TRAP 8'hff
`define CAUSE_PIN 0
`define CAUSE_POWER_ON 1
`define CAUSE_VOLT 2
`define CAUSE_WATCHDOG 3
`define CAUSE_TRAP 4
`define CAUSE_ACCESS 5
`define CAUSE_PARITY 6
`define PEND_RESET 43'h000_0000_0000

`endif

// ### logic/irq_vector_pkg.sv
// types shared by the interrupt source resolver
package irq_vector_pkg;

	typedef enum {ST_IDLE, ST_PRESENT} arb_state_t;

	typedef enum logic [1:0] {KIND_NONE, KIND_RESET, KIND_BREAK, KIND_MASKABLE} vec_kind_t;

endpackage : irq_vector_pkg

// ### logic/pending_bank.sv
// bank of sticky request flags, set wins over clear
`timescale 1ns/1ns
module pending_bank #(
	parameter int WIDTH = 43
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clr,
	output logic [WIDTH-1:0] pend_q
);

	logic [WIDTH-1:0] pend_d;

	// an event landing on its own clear cycle is kept
	assign pend_d = set | (pend_q & ~clr);

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_d;
		end
	end

endmodule : pending_bank

// ### logic/irq_vector_resolver.sv
// interrupt source resolver and vector supplier for the cpu core
`timescale 1ns/1ns
`include "irq_vector_defs.svh"

// Overview of operation
// - simultaneous maskable requests served lowest priority number first, 0 to 42
// - timer channel 2 end: priority 22, vector 0034
// - timer channel 3 end: priority 23, vector 0036
// - sar end priority 24 vector 0038; delta-sigma end priority 27 vector 0044
// - calendar cycle or alarm: priority 25, vector 003a
// - 12-bit interval timer: priority 26, vector 003c
// - timer channels 4 and 5: priorities 28, 29, vectors 0046, 0048
// - pin edges 6 and 7: priorities 30, 31, vectors 004a, 004c
// - timer channels 6 and 7: priorities 34, 35, vectors 0054, 0056
// - 8-bit interval 00 and 01: priorities 36, 37, vectors 0058, 005a
// - 8-bit interval 10 and 11: priorities 40, 41, vectors 0068, 006a
// - oscillator correction end: priority 38, vector 005c
// - power switch detection: lowest priority 42, vector 006c
// - software break is non-maskable, no priority, vector 007e
// - every reset source restarts through vector 0000
// - opcode ff traps to reset unless issued by a debug emulator
// - voltage detect mode bit set: voltage event causes reset
// - voltage detect mode bit clear: voltage event raises maskable interrupt
// - watchdog interval interrupt only when its option bit is set
// - pin edge 0 still accepted while running from backup supply
// - watchdog interval: priority 0, vector 0004, at 75 percent overflow
module irq_vector_resolver (
	input wire logic clk,
	input wire logic rst,
	input wire logic [42:0] irq_mask,
	input wire logic timer_ch2_irq,
	input wire logic timer_ch3_irq,
	input wire logic sar_conversion_end_irq,
	input wire logic calendar_cycle_alarm_irq,
	input wire logic interval12_irq,
	input wire logic delta_sigma_end_irq,
	input wire logic timer_ch4_irq,
	input wire logic timer_ch5_irq,
	input wire logic pin_edge0_irq,
	input wire logic pin_edge6_irq,
	input wire logic pin_edge7_irq,
	input wire logic comparator0_irq,
	input wire logic comparator1_irq,
	input wire logic timer_ch6_irq,
	input wire logic timer_ch7_irq,
	input wire logic interval8_ch00_irq,
	input wire logic interval8_ch01_irq,
	input wire logic osc_correction_end_irq,
	input wire logic osc_stop_irq,
	input wire logic interval8_ch10_irq,
	input wire logic interval8_ch11_irq,
	input wire logic power_switch_irq,
	input wire logic backup_supply_active,
	input wire logic [15:0] wdt_count,
	input wire logic [15:0] wdt_overflow_count,
	input wire logic watchdog_interval_irq_option,
	input wire logic watchdog_overflow_reset,
	input wire logic voltage_detect_event,
	input wire logic voltage_detect_mode_bit,
	input wire logic reset_pin_event,
	input wire logic power_on_event,
	input wire logic illegal_memory_access_reset,
	input wire logic ram_parity_error_reset,
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	input wire logic debug_emulation,
	input wire logic software_break_instruction,
	input wire logic vec_ack,
	output logic vec_req_q,
	output logic [15:0] vec_addr_q,
	output irq_vector_pkg::vec_kind_t vec_kind_q,
	output logic reset_req_q,
	output logic [6:0] reset_cause_q,
	output logic [42:0] pending_q
);

	// ----------------------------------------
	// watchdog interval point
	// ----------------------------------------
	logic [16:0] wdt_thr_sum;
	logic [15:0] wdt_thr;
	logic wdt_at_thr;
	logic wdt_at_thr_q;
	logic wdt_interval_hit;

	assign wdt_thr_sum = {2'b00, wdt_overflow_count[15:1]} + {3'b000, wdt_overflow_count[15:2]};
	assign wdt_thr = wdt_thr_sum[15:0];
	assign wdt_at_thr = (wdt_count == wdt_thr);
	// only the first cycle at the threshold counts, a stalled count fires once
	assign wdt_interval_hit = wdt_at_thr & ~wdt_at_thr_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			wdt_at_thr_q <= 1'b0;
		end else begin
			wdt_at_thr_q <= wdt_at_thr;
		end
	end

	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	logic trap_hit;
	logic volt_reset;
	logic volt_irq;
	logic [6:0] rst_src;
	logic any_reset;

	assign trap_hit = opcode_valid & (opcode == `OPCODE_TRAP) & ~debug_emulation;
	assign volt_reset = voltage_detect_event & voltage_detect_mode_bit;
	assign volt_irq = voltage_detect_event & ~voltage_detect_mode_bit;

	assign rst_src[`CAUSE_PIN] = reset_pin_event;
	assign rst_src[`CAUSE_POWER_ON] = power_on_event;
	assign rst_src[`CAUSE_VOLT] = volt_reset;
	assign rst_src[`CAUSE_WATCHDOG] = watchdog_overflow_reset;
	assign rst_src[`CAUSE_TRAP] = trap_hit;
	assign rst_src[`CAUSE_ACCESS] = illegal_memory_access_reset;
	assign rst_src[`CAUSE_PARITY] = ram_parity_error_reset;
	assign any_reset = |rst_src;

	// ----------------------------------------
	// request map into priority order
	// ----------------------------------------
	logic [42:0] req_set;
	logic [42:0] req_clr;
	logic [42:0] eligible;

	always_comb begin
		req_set = '0;
		req_set[`PRI_WDT_INTERVAL] = wdt_interval_hit & watchdog_interval_irq_option;
		req_set[`PRI_VOLT_DETECT] = volt_irq;
		// pin 0 buffer on internal supply
		req_set[`PRI_PIN_EDGE0] = pin_edge0_irq;
		req_set[`PRI_TIMER_CH2] = timer_ch2_irq;
		req_set[`PRI_TIMER_CH3] = timer_ch3_irq;
		req_set[`PRI_SAR_END] = sar_conversion_end_irq;
		req_set[`PRI_CALENDAR] = calendar_cycle_alarm_irq;
		req_set[`PRI_INTERVAL12] = interval12_irq;
		req_set[`PRI_DELTA_SIGMA] = delta_sigma_end_irq;
		req_set[`PRI_TIMER_CH4] = timer_ch4_irq;
		req_set[`PRI_TIMER_CH5] = timer_ch5_irq;
		// other pin buffers lose power on backup supply
		req_set[`PRI_PIN_EDGE6] = pin_edge6_irq & ~backup_supply_active;
		req_set[`PRI_PIN_EDGE7] = pin_edge7_irq & ~backup_supply_active;
		req_set[`PRI_COMPARATOR0] = comparator0_irq;
		req_set[`PRI_COMPARATOR1] = comparator1_irq;
		req_set[`PRI_TIMER_CH6] = timer_ch6_irq;
		req_set[`PRI_TIMER_CH7] = timer_ch7_irq;
		req_set[`PRI_INTERVAL8_00] = interval8_ch00_irq;
		req_set[`PRI_INTERVAL8_01] = interval8_ch01_irq;
		req_set[`PRI_OSC_CORRECT] = osc_correction_end_irq;
		req_set[`PRI_OSC_STOP] = osc_stop_irq;
		req_set[`PRI_INTERVAL8_10] = interval8_ch10_irq;
		req_set[`PRI_INTERVAL8_11] = interval8_ch11_irq;
		req_set[`PRI_POWER_SWITCH] = power_switch_irq;
	end

	pending_bank #(
		.WIDTH(`IRQ_COUNT)
	) u_pending (
		.clk(clk),
		.rst(rst),
		.set(req_set),
		.clr(req_clr),
		.pend_q(pending_q)
	);

	assign eligible = pending_q & ~irq_mask;

	// ----------------------------------------
	// priority pick and vector lookup
	// ----------------------------------------
	logic [5:0] win_idx;
	logic win_found;
	logic [15:0] win_vec;

	always_comb begin
		win_idx = 6'h00;
		win_found = 1'b0;
		for (int i = `IRQ_COUNT - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				win_idx = 6'(i);
				win_found = 1'b1;
			end
		end
	end

	always_comb begin
		case (win_idx)
			`PRI_WDT_INTERVAL: win_vec = `VEC_WDT_INTERVAL;
			`PRI_VOLT_DETECT: win_vec = `VEC_VOLT_DETECT;
			`PRI_PIN_EDGE0: win_vec = `VEC_PIN_EDGE0;
			`PRI_TIMER_CH2: win_vec = `VEC_TIMER_CH2;
			`PRI_TIMER_CH3: win_vec = `VEC_TIMER_CH3;
			`PRI_SAR_END: win_vec = `VEC_SAR_END;
			`PRI_DELTA_SIGMA: win_vec = `VEC_DELTA_SIGMA;
			`PRI_CALENDAR: win_vec = `VEC_CALENDAR;
			`PRI_INTERVAL12: win_vec = `VEC_INTERVAL12;
			`PRI_TIMER_CH4: win_vec = `VEC_TIMER_CH4;
			`PRI_TIMER_CH5: win_vec = `VEC_TIMER_CH5;
			`PRI_PIN_EDGE6: win_vec = `VEC_PIN_EDGE6;
			`PRI_PIN_EDGE7: win_vec = `VEC_PIN_EDGE7;
			`PRI_COMPARATOR0: win_vec = `VEC_COMPARATOR0;
			`PRI_COMPARATOR1: win_vec = `VEC_COMPARATOR1;
			`PRI_TIMER_CH6: win_vec = `VEC_TIMER_CH6;
			`PRI_TIMER_CH7: win_vec = `VEC_TIMER_CH7;
			`PRI_INTERVAL8_00: win_vec = `VEC_INTERVAL8_00;
			`PRI_INTERVAL8_01: win_vec = `VEC_INTERVAL8_01;
			`PRI_OSC_CORRECT: win_vec = `VEC_OSC_CORRECT;
			`PRI_OSC_STOP: win_vec = `VEC_OSC_STOP;
			`PRI_INTERVAL8_10: win_vec = `VEC_INTERVAL8_10;
			`PRI_INTERVAL8_11: win_vec = `VEC_INTERVAL8_11;
			`PRI_POWER_SWITCH: win_vec = `VEC_POWER_SWITCH;
			default: win_vec = `VEC_RESET;
		endcase
	end

	// ----------------------------------------
	// presentation to the core
	// ----------------------------------------
	irq_vector_pkg::arb_state_t state_q;
	irq_vector_pkg::arb_state_t state_d;
	logic break_pend_q;
	logic break_pend_d;
	logic [5:0] served_idx_q;
	logic idle;
	logic take_reset;
	logic take_break;
	logic take_mask;
	logic done;

	assign idle = (state_q == irq_vector_pkg::ST_IDLE);
	// reset beats everything, even a vector already on offer
	assign take_reset = any_reset;
	assign take_break = idle & ~any_reset & (break_pend_q | software_break_instruction);
	assign take_mask = idle & ~any_reset & ~take_break & win_found;
	assign done = ~idle & vec_ack;

	always_comb begin
		req_clr = '0;
		if (take_reset) begin
			req_clr = '1;
		end else if (done && vec_kind_q == irq_vector_pkg::KIND_MASKABLE) begin
			req_clr[served_idx_q] = 1'b1;
		end
	end

	always_comb begin
		case (state_q)
			irq_vector_pkg::ST_IDLE: begin
				state_d = (take_reset | take_break | take_mask) ? irq_vector_pkg::ST_PRESENT
					: irq_vector_pkg::ST_IDLE;
			end
			irq_vector_pkg::ST_PRESENT: begin
				state_d = (done & ~take_reset) ? irq_vector_pkg::ST_IDLE
					: irq_vector_pkg::ST_PRESENT;
			end
			default: state_d = irq_vector_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= irq_vector_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// break is latched, no mask
	// a new break landing on the serving cycle of a latched one is kept
	assign break_pend_d = take_break ? (break_pend_q & software_break_instruction)
		: (break_pend_q | software_break_instruction);

	always_ff @(posedge clk) begin
		if (rst) begin
			break_pend_q <= 1'b0;
		end else begin
			break_pend_q <= break_pend_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vec_req_q <= 1'b0;
			vec_addr_q <= `VEC_RESET;
			vec_kind_q <= irq_vector_pkg::KIND_NONE;
			served_idx_q <= 6'h00;
		end else if (take_reset) begin
			vec_req_q <= 1'b1;
			vec_addr_q <= `VEC_RESET;
			vec_kind_q <= irq_vector_pkg::KIND_RESET;
		end else if (take_break) begin
			vec_req_q <= 1'b1;
			vec_addr_q <= `VEC_SOFT_BREAK;
			vec_kind_q <= irq_vector_pkg::KIND_BREAK;
		end else if (take_mask) begin
			vec_req_q <= 1'b1;
			vec_addr_q <= win_vec;
			vec_kind_q <= irq_vector_pkg::KIND_MASKABLE;
			served_idx_q <= win_idx;
		end else if (done) begin
			vec_req_q <= 1'b0;
			vec_kind_q <= irq_vector_pkg::KIND_NONE;
		end
	end

	// causes stay sticky until system reset so boot code can read them
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_req_q <= 1'b0;
			reset_cause_q <= 7'h00;
		end else begin
			reset_req_q <= any_reset;
			reset_cause_q <= reset_cause_q | rst_src;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_hold_vector;
		@(posedge clk) disable iff (rst)
		vec_req_q && !vec_ack && !any_reset |=> vec_req_q && $stable(vec_addr_q);
	endproperty
	a_hold_vector: assert property (p_hold_vector)
		else $error("vector changed before fetch");

	property p_order;
		@(posedge clk) disable iff (rst)
		take_mask && eligible[`PRI_TIMER_CH2] && eligible[`PRI_POWER_SWITCH]
			&& eligible[21:0] == 22'h0 |=> vec_addr_q == 16'h0034;
	endproperty
	a_order: assert property (p_order)
		else $error("lower priority served first");

	property p_power_switch;
		@(posedge clk) disable iff (rst)
		take_mask && eligible == (43'h1 << 42) |=> vec_addr_q == 16'h006c;
	endproperty
	a_power_switch: assert property (p_power_switch)
		else $error("power switch vector wrong");

	property p_break;
		@(posedge clk) disable iff (rst)
		idle && software_break_instruction && !any_reset
			|=> vec_req_q && vec_addr_q == 16'h007e && vec_kind_q == irq_vector_pkg::KIND_BREAK;
	endproperty
	a_break: assert property (p_break)
		else $error("break vector not presented");

	property p_reset_vec;
		@(posedge clk) disable iff (rst)
		(reset_pin_event || watchdog_overflow_reset || ram_parity_error_reset)
			|=> reset_req_q && vec_addr_q == 16'h0000
			&& (pending_q & ~$past(req_set)) == '0;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset source not through vector 0000");

	property p_trap;
		@(posedge clk) disable iff (rst)
		opcode_valid && opcode == 8'hff |=> reset_cause_q[4] == !$past(debug_emulation)
			|| $past(reset_cause_q[4]);
	endproperty
	a_trap: assert property (p_trap)
		else $error("illegal opcode trap mishandled");

	property p_volt_reset;
		@(posedge clk) disable iff (rst)
		voltage_detect_event && voltage_detect_mode_bit |=> reset_req_q && reset_cause_q[2];
	endproperty
	a_volt_reset: assert property (p_volt_reset)
		else $error("voltage event did not reset");

	property p_volt_irq;
		@(posedge clk) disable iff (rst)
		voltage_detect_event && !voltage_detect_mode_bit && !any_reset
			|=> pending_q[1] && !reset_req_q;
	endproperty
	a_volt_irq: assert property (p_volt_irq)
		else $error("voltage event did not raise interrupt");

	property p_wdt_option;
		@(posedge clk) disable iff (rst)
		!watchdog_interval_irq_option && !pending_q[0] |=> !pending_q[0];
	endproperty
	a_wdt_option: assert property (p_wdt_option)
		else $error("watchdog interval raised without option");

	property p_pin0_backup;
		@(posedge clk) disable iff (rst)
		pin_edge0_irq && backup_supply_active && !any_reset |=> pending_q[2];
	endproperty
	a_pin0_backup: assert property (p_pin0_backup)
		else $error("pin edge 0 lost on backup supply");

endmodule : irq_vector_resolver

// ### sim/core_fetch_model.sv
// cpu core side model: fetches offered vectors after a chosen delay
`timescale 1ns/1ns
module core_fetch_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic vec_req_q,
	input wire logic [15:0] vec_addr_q,
	input wire irq_vector_pkg::vec_kind_t vec_kind_q,
	input wire logic [3:0] ack_delay,
	output logic vec_ack,
	output logic [15:0] fetch_addr,
	output irq_vector_pkg::vec_kind_t fetch_kind,
	output int fetch_count,
	output int hold_err
);
	logic [3:0] wait_q;
	logic [15:0] seen_addr;
	initial begin
		vec_ack = 1'b0;
		wait_q = 4'h0;
		seen_addr = 16'h0000;
		fetch_addr = 16'h0000;
		fetch_kind = irq_vector_pkg::KIND_NONE;
		fetch_count = 0;
		hold_err = 0;
	end
	always @(posedge clk) begin
		// ack sampled here, so the vector is taken at this same edge
		if (vec_ack === 1'b1) begin
			fetch_addr = vec_addr_q;
			fetch_kind = vec_kind_q;
			fetch_count++;
		end
		#5;
		if (rst || !vec_req_q || vec_ack) begin
			vec_ack = 1'b0;
			wait_q = 4'h0;
		end else begin
			if (wait_q != 4'h0 && vec_addr_q !== seen_addr)
				hold_err++;
			seen_addr = vec_addr_q;
			// slow core: ack only after the chosen wait
			if (wait_q >= ack_delay)
				vec_ack = 1'b1;
			else
				wait_q++;
		end
	end
endmodule : core_fetch_model

// ### sim/interrupt_source_vector_priority_tb_top.sv
// self-checking testbench for the interrupt source resolver
`timescale 1ns/1ns
module interrupt_source_vector_priority_tb_top;
	localparam irq_vector_pkg::vec_kind_t KM = irq_vector_pkg::KIND_MASKABLE;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [42:0] irq_mask = '0;
	logic [42:0] req = '0;
	logic [6:0] rsrc = '0;
	logic backup = 1'b0;
	logic [15:0] wdt_count = 16'h0000;
	logic [15:0] wdt_ovf = 16'h0100;
	logic wdt_opt = 1'b0;
	logic lvd_mode = 1'b1;
	logic [7:0] op = 8'hff;
	logic dbg = 1'b0;
	logic soft_break = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic vec_ack;
	logic vec_req_q;
	logic reset_req_q;
	logic [15:0] vec_addr_q;
	logic [15:0] fetch_addr;
	irq_vector_pkg::vec_kind_t vec_kind_q;
	irq_vector_pkg::vec_kind_t fetch_kind;
	logic [6:0] reset_cause_q;
	logic [42:0] pending_q;
	int fetch_count;
	int hold_err;
	int failures = 0;
	int samples_checked = 0;
	// order: pin edge 0, then priorities 22 to 42
	logic [15:0] vec [22] = '{16'h0008, 16'h0034, 16'h0036, 16'h0038, 16'h003a, 16'h003c,
		16'h0044, 16'h0046, 16'h0048, 16'h004a, 16'h004c, 16'h0050, 16'h0052, 16'h0054,
		16'h0056, 16'h0058, 16'h005a, 16'h005c, 16'h0060, 16'h0068, 16'h006a, 16'h006c};

	always #25 clk = ~clk;

	irq_vector_resolver dut (.clk(clk), .rst(rst), .irq_mask(irq_mask),
		.timer_ch2_irq(req[22]), .timer_ch3_irq(req[23]), .sar_conversion_end_irq(req[24]),
		.calendar_cycle_alarm_irq(req[25]), .interval12_irq(req[26]),
		.delta_sigma_end_irq(req[27]), .timer_ch4_irq(req[28]), .timer_ch5_irq(req[29]),
		.pin_edge0_irq(req[2]), .pin_edge6_irq(req[30]), .pin_edge7_irq(req[31]),
		.comparator0_irq(req[32]), .comparator1_irq(req[33]), .timer_ch6_irq(req[34]),
		.timer_ch7_irq(req[35]), .interval8_ch00_irq(req[36]), .interval8_ch01_irq(req[37]),
		.osc_correction_end_irq(req[38]), .osc_stop_irq(req[39]),
		.interval8_ch10_irq(req[40]), .interval8_ch11_irq(req[41]),
		.power_switch_irq(req[42]), .backup_supply_active(backup), .wdt_count(wdt_count),
		.wdt_overflow_count(wdt_ovf), .watchdog_interval_irq_option(wdt_opt),
		.watchdog_overflow_reset(rsrc[3]), .voltage_detect_event(rsrc[2]),
		.voltage_detect_mode_bit(lvd_mode), .reset_pin_event(rsrc[0]),
		.power_on_event(rsrc[1]), .illegal_memory_access_reset(rsrc[5]),
		.ram_parity_error_reset(rsrc[6]), .opcode_valid(rsrc[4]), .opcode(op),
		.debug_emulation(dbg), .software_break_instruction(soft_break), .vec_ack(vec_ack),
		.vec_req_q(vec_req_q), .vec_addr_q(vec_addr_q), .vec_kind_q(vec_kind_q),
		.reset_req_q(reset_req_q), .reset_cause_q(reset_cause_q), .pending_q(pending_q));

	core_fetch_model core (.clk(clk), .rst(rst), .vec_req_q(vec_req_q),
		.vec_addr_q(vec_addr_q), .vec_kind_q(vec_kind_q), .ack_delay(ack_delay),
		.vec_ack(vec_ack), .fetch_addr(fetch_addr), .fetch_kind(fetch_kind),
		.fetch_count(fetch_count), .hold_err(hold_err));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [42:0] exp, input logic [42:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// inputs always change 5 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick

	task automatic fetch(input logic [15:0] addr, input irq_vector_pkg::vec_kind_t kind);
		int n;
		n = fetch_count;
		for (int t = 0; t < 60 && fetch_count == n; t++)
			tick(1);
		chk("fetch count", 43'(n + 1), 43'(fetch_count));
		chk("vector address", 43'(addr), 43'(fetch_addr));
		chk("vector kind", 43'(kind), 43'(fetch_kind));
	endtask : fetch

	task automatic end_of_test();
		chk("vector hold", 43'h0, 43'(hold_err));
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_table();
		for (int i = 0; i < 22; i++) begin
			ack_delay = 4'(i % 4);
			req[(i == 0) ? 2 : 21 + i] = 1'b1;
			tick(1);
			req = '0;
			fetch(vec[i], KM);
			chk("flag cleared", 43'h0, pending_q);
		end
		$display("table test done");
	endtask : t_table

	task automatic t_order();
		irq_mask = 43'h1 << 2;
		ack_delay = 4'h1;
		for (int i = 0; i < 22; i++)
			req[(i == 0) ? 2 : 21 + i] = 1'b1;
		tick(1);
		req = '0;
		for (int i = 0; i < 22; i++)
			if (i != 0)
				fetch(vec[i], KM);
		chk("masked flag kept", 43'h1 << 2, pending_q);
		irq_mask = '0;
		fetch(16'h0008, KM);
		$display("order test done");
	endtask : t_order

	task automatic t_break();
		irq_mask = '1;
		soft_break = 1'b1;
		tick(1);
		soft_break = 1'b0;
		fetch(16'h007e, irq_vector_pkg::KIND_BREAK);
		irq_mask = '0;
		ack_delay = 4'h6;
		req[42] = 1'b1;
		soft_break = 1'b1;
		tick(1);
		req = '0;
		soft_break = 1'b0;
		fetch(16'h007e, irq_vector_pkg::KIND_BREAK);
		fetch(16'h006c, KM);
		req[42] = 1'b1;
		tick(3);
		req = '0;
		soft_break = 1'b1;
		tick(1);
		soft_break = 1'b0;
		fetch(16'h006c, KM);
		fetch(16'h007e, irq_vector_pkg::KIND_BREAK);
		$display("break test done");
	endtask : t_break

	task automatic t_reset();
		logic [6:0] cause;
		cause = '0;
		ack_delay = 4'h0;
		irq_mask = '1;
		req[40] = 1'b1;
		tick(1);
		req = '0;
		for (int i = 0; i < 7; i++) begin
			rsrc[i] = 1'b1;
			tick(1);
			rsrc = '0;
			cause[i] = 1'b1;
			chk("reset request", 43'h1, 43'(reset_req_q));
			fetch(16'h0000, irq_vector_pkg::KIND_RESET);
			chk("reset cause", 43'(cause), 43'(reset_cause_q));
			chk("pending wiped", 43'h0, pending_q);
		end
		dbg = 1'b1;
		rsrc[4] = 1'b1;
		tick(1);
		rsrc = '0;
		chk("emulator opcode", 43'h0, 43'(reset_req_q));
		dbg = 1'b0;
		op = 8'hfe;
		rsrc[4] = 1'b1;
		tick(1);
		rsrc = '0;
		op = 8'hff;
		chk("other opcode", 43'h0, 43'(reset_req_q));
		irq_mask = '0;
		lvd_mode = 1'b0;
		rsrc[2] = 1'b1;
		tick(1);
		rsrc = '0;
		chk("voltage no reset", 43'h0, 43'(reset_req_q));
		fetch(16'h0006, KM);
		lvd_mode = 1'b1;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(1);
		chk("cause after reset", 43'h0, 43'(reset_cause_q));
		$display("reset test done");
	endtask : t_reset

	task automatic t_watchdog();
		wdt_count = 16'h00c0;
		tick(3);
		chk("interval refused", 43'h0, pending_q);
		wdt_count = 16'h00bf;
		wdt_opt = 1'b1;
		tick(3);
		chk("interval early", 43'h0, pending_q);
		wdt_count = 16'h00c0;
		fetch(16'h0004, KM);
		wdt_count = 16'h0000;
		$display("watchdog test done");
	endtask : t_watchdog

	task automatic t_backup();
		backup = 1'b1;
		req[2] = 1'b1;
		req[30] = 1'b1;
		req[31] = 1'b1;
		tick(1);
		req = '0;
		fetch(16'h0008, KM);
		tick(3);
		chk("pin 6 and 7 refused", 43'h0, pending_q);
		backup = 1'b0;
		$display("backup test done");
	endtask : t_backup

	initial begin
		repeat (8) @(posedge clk);
		#5;
		rst = 1'b0;
		chk("vector after reset", 43'h0, 43'({vec_req_q, vec_addr_q}));
		tick(1);
		t_table();
		t_order();
		t_break();
		t_reset();
		t_watchdog();
		t_backup();
		end_of_test();
	end

	// cut a hang short, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("watchdog limit reached");
		end_of_test();
	end
endmodule : interrupt_source_vector_priority_tb_top
